/* hw/pic_pkg.sv */
package pic_pkg;

  // Request inputs and priority field geometry.
  localparam int NUM_REQ         = 12;
  localparam int FIELD_W         = 2;
  localparam int FIELDS_PER_BYTE = 4;
  localparam int NUM_PRIO_REGS   = 3;

  // Priority setting register byte addresses, write only.
  localparam logic [7:0] PRIO_0_TO_3_ADDR  = 8'h7c;
  localparam logic [7:0] PRIO_4_TO_7_ADDR  = 8'h7d;
  localparam logic [7:0] PRIO_8_TO_11_ADDR = 8'h7e;
  localparam logic [7:0] PRIO_REG_RESET    = 8'hff;

  // Priority encodings shared by fields and the core level.
  localparam logic [1:0] PRIO_NEVER     = 2'b11;
  localparam logic [1:0] RANK_DISABLED  = 2'd3;

  // Vector table: input 0 at the top, each next input two bytes lower.
  localparam logic [15:0] VECTOR_TOP  = 16'hfffa;
  localparam logic [15:0] VECTOR_STEP = 16'h0002;

  // Core side timing: nine instruction cycles of two system clocks each.
  localparam int ACK_INSTR_CYCLES = 9;
  localparam int CLKS_PER_INSTR   = 2;
  localparam int ACK_CLKS         = ACK_INSTR_CYCLES * CLKS_PER_INSTR;

  // Core status after reset: level disabled, global enable clear.
  localparam logic [1:0] PS_LEVEL_RESET = 2'b11;
  localparam logic       PS_IEN_RESET   = 1'b0;
  localparam logic [15:0] PC_RESET      = 16'h0000;

  // Rank of a two-bit priority code: 1 better, 2 worse, 3 never.
  function automatic logic [1:0] prio_rank(input logic [1:0] code);
    if (!code[1]) begin
      prio_rank = 2'd1;
    end else if (!code[0]) begin
      prio_rank = 2'd2;
    end else begin
      prio_rank = RANK_DISABLED;
    end
  endfunction

endpackage

/* hw/pic_if.sv */
`timescale 1ns/100ps
interface pic_if (
  input wire logic clk,
  input wire logic reset
);
  logic        irq_valid;
  logic [1:0]  irq_priority;
  logic [15:0] irq_vector;
  logic [3:0]  irq_source;
  logic        wake;
  logic        sleep_active;
  logic        cfg_write;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_data;

  // Controller end: drives the forwarded request and the wake signal.
  modport dev_mp (
    input  clk,
    input  reset,
    input  sleep_active,
    input  cfg_write,
    input  cfg_addr,
    input  cfg_data,
    output irq_valid,
    output irq_priority,
    output irq_vector,
    output irq_source,
    output wake
  );

  // Core end: consumes the request, writes the priority bytes.
  modport cpu_mp (
    input  clk,
    input  reset,
    input  irq_valid,
    input  irq_priority,
    input  irq_vector,
    input  irq_source,
    input  wake,
    output sleep_active,
    output cfg_write,
    output cfg_addr,
    output cfg_data
  );
endinterface

/* hw/pic_controller.sv */
`timescale 1ns/100ps
module pic_controller #(
  parameter int NUM_REQ = pic_pkg::NUM_REQ
) (
  pic_if.dev_mp             link,
  input  wire logic [NUM_REQ-1:0] req
);

  // Write decode to a one-hot byte strobe, one bit per priority byte.
  function automatic logic [2:0] byte_select(input logic [7:0] addr);
    byte_select = 3'b000;
    case (addr)
      pic_pkg::PRIO_0_TO_3_ADDR:  byte_select = 3'b001;
      pic_pkg::PRIO_4_TO_7_ADDR:  byte_select = 3'b010;
      pic_pkg::PRIO_8_TO_11_ADDR: byte_select = 3'b100;
      default:                    byte_select = 3'b000;
    endcase
  endfunction

  // Vector address of an input: top entry minus two bytes per index.
  function automatic logic [15:0] vector_of(input logic [3:0] index);
    vector_of = pic_pkg::VECTOR_TOP - (pic_pkg::VECTOR_STEP * {12'h000, index});
  endfunction

  logic [7:0]         prio_bytes_reg [pic_pkg::NUM_PRIO_REGS];
  logic [2:0]         write_sel;
  logic [1:0]         field      [NUM_REQ];
  logic [NUM_REQ-1:0] eligible;
  logic               best_valid;
  logic [1:0]         best_rank;
  logic [1:0]         best_code;
  logic [3:0]         best_index;
  logic               irq_valid_reg;
  logic [1:0]         irq_priority_reg;
  logic [15:0]        irq_vector_reg;
  logic [3:0]         irq_source_reg;
  logic               wake_reg;

  assign write_sel = byte_select(link.cfg_addr);

  // Priority bytes reset to all ones, so every input starts as never
  // forwarded; nothing reaches the core until software lowers a field.
  // There is no read path: the bytes are write only, and a whole byte is
  // replaced on every write, which is why bit operations cannot work.
  generate
    for (genvar b = 0; b < pic_pkg::NUM_PRIO_REGS; b++) begin : g_prio_byte
      always_ff @(posedge link.clk) begin
        if (link.reset) begin
          prio_bytes_reg[b] <= pic_pkg::PRIO_REG_RESET;
        end else if (link.cfg_write && write_sel[b]) begin
          prio_bytes_reg[b] <= link.cfg_data;
        end
      end
    end
  endgenerate

  // Each input takes its two-bit field, lowest inputs in the lowest bits.
  // An input is eligible while it is held high and its field is not 11.
  // Spare inputs go through the same path with no special case.
  generate
    for (genvar i = 0; i < NUM_REQ; i++) begin : g_field
      localparam int BYTE_IDX = i / pic_pkg::FIELDS_PER_BYTE;
      localparam int LSB      = (i % pic_pkg::FIELDS_PER_BYTE) * pic_pkg::FIELD_W;
      assign field[i]    = prio_bytes_reg[BYTE_IDX][LSB +: pic_pkg::FIELD_W];
      assign eligible[i] = req[i] && (field[i] != pic_pkg::PRIO_NEVER);
    end
  endgenerate

  // Arbitration scans upward and replaces the candidate only on a strictly
  // better rank, so among equal ranks the lowest input keeps the grant.
  always_comb begin
    best_valid = 1'b0;
    best_rank  = pic_pkg::RANK_DISABLED;
    best_code  = pic_pkg::PRIO_NEVER;
    best_index = 4'h0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (eligible[i] && (pic_pkg::prio_rank(field[i]) < best_rank)) begin
        best_valid = 1'b1;
        best_rank  = pic_pkg::prio_rank(field[i]);
        best_code  = field[i];
        best_index = i[3:0];
      end
    end
  end

  // The winner is registered every cycle; because requests are levels the
  // grant can move to a better source at any time, and it drops one cycle
  // after the source clears its own flag.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      irq_valid_reg <= 1'b0;
    end else begin
      irq_valid_reg <= best_valid;
    end
  end

  // Priority code travels with the request so the core can compare it.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      irq_priority_reg <= pic_pkg::PRIO_NEVER;
    end else begin
      irq_priority_reg <= best_code;
    end
  end

  // Vector and source index are fixed by the input number.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      irq_vector_reg <= pic_pkg::VECTOR_TOP;
      irq_source_reg <= 4'h0;
    end else if (best_valid) begin
      irq_vector_reg <= vector_of(best_index);
      irq_source_reg <= best_index;
    end
  end

  // Any forwarded request wakes a sleeping core; the enable flag and level
  // are not looked at here, the core decides afterwards whether to take it.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= link.sleep_active && best_valid;
    end
  end

  assign link.irq_valid    = irq_valid_reg;
  assign link.irq_priority = irq_priority_reg;
  assign link.irq_vector   = irq_vector_reg;
  assign link.irq_source   = irq_source_reg;
  assign link.wake         = wake_reg;

endmodule

/* hw/pic_core_end.sv */
`timescale 1ns/100ps
module pic_core_end #(
  parameter int STACK_DEPTH = 16,
  parameter int SP_W        = 4
) (
  pic_if.cpu_mp             link,
  input  wire logic         instr_done,
  input  wire logic         return_from_interrupt,
  input  wire logic         sleep_req,
  input  wire logic         ps_write,
  input  wire logic         ps_ien_in,
  input  wire logic [1:0]   ps_level_in,
  input  wire logic         cfg_valid,
  input  wire logic [7:0]   cfg_addr_in,
  input  wire logic [7:0]   cfg_data_in,
  output logic [15:0]       program_counter,
  output logic [SP_W-1:0]   stack_pointer,
  output logic [1:0]        cpu_level,
  output logic              ien,
  output logic              accepted,
  output logic              acknowledging,
  output logic              sleeping
);

  typedef enum logic [1:0] {PIC_RUN, PIC_ACK, PIC_SLEEP} pic_state_t;

  localparam logic [4:0] ACK_LAST = 5'(pic_pkg::ACK_CLKS - 1);

  pic_state_t       state_reg;
  logic [4:0]       ack_count_reg;
  logic [15:0]      pc_reg;
  logic [1:0]       level_reg;
  logic             ien_reg;
  logic [SP_W-1:0]  sp_reg;
  logic [15:0]      vector_reg;
  logic [1:0]       taken_prio_reg;
  logic [15:0]      stack_mem [STACK_DEPTH];
  logic             take;
  logic             cfg_write_reg;
  logic [7:0]       cfg_addr_reg;
  logic [7:0]       cfg_data_reg;

  // Requests are looked at only when an instruction finishes; acceptance
  // needs the global enable and a strictly better rank than the level.
  assign take = (state_reg == PIC_RUN) && instr_done && link.irq_valid && ien_reg &&
                (pic_pkg::prio_rank(link.irq_priority) < pic_pkg::prio_rank(level_reg));

  // Mode sequencing: the acknowledge lasts nine instruction cycles. Sleep
  // is refused while a request is waiting; a wake returns to run.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      state_reg     <= PIC_RUN;
      ack_count_reg <= 5'h00;
    end else begin
      case (state_reg)
        PIC_RUN: begin
          ack_count_reg <= 5'h00;
          if (take) begin
            state_reg <= PIC_ACK;
          end else if (sleep_req && !link.irq_valid) begin
            state_reg <= PIC_SLEEP;
          end
        end
        PIC_ACK: begin
          ack_count_reg <= ack_count_reg + 5'h01;
          if (ack_count_reg == ACK_LAST) begin
            state_reg <= PIC_RUN;
          end
        end
        PIC_SLEEP: begin
          if (link.wake) begin
            state_reg <= PIC_RUN;
          end
        end
        default: state_reg <= PIC_RUN;
      endcase
    end
  end

  // Capture the request at acceptance; it may drop during the acknowledge.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      vector_reg     <= pic_pkg::VECTOR_TOP;
      taken_prio_reg <= pic_pkg::PRIO_NEVER;
    end else if (take) begin
      vector_reg     <= link.irq_vector;
      taken_prio_reg <= link.irq_priority;
    end
  end

  // Stack: PC goes first, status second, each push one word downward.
  // A return pops both words at once. No overflow check is made.
  always_ff @(posedge link.clk) begin
    if (state_reg == PIC_ACK && ack_count_reg == 5'h00) begin
      stack_mem[sp_reg] <= pc_reg;
    end else if (state_reg == PIC_ACK && ack_count_reg == 5'h01) begin
      stack_mem[sp_reg] <= {13'h0000, ien_reg, level_reg};
    end
  end

  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      sp_reg <= SP_W'(STACK_DEPTH - 1);
    end else if (state_reg == PIC_ACK && ack_count_reg < 5'h02) begin
      sp_reg <= sp_reg - 1'b1;
    end else if (state_reg == PIC_RUN && return_from_interrupt) begin
      sp_reg <= sp_reg + SP_W'(2);
    end
  end

  // Program counter steps per instruction, takes the vector at the end of
  // the acknowledge and comes back from the stack on a return.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      pc_reg <= pic_pkg::PC_RESET;
    end else if (state_reg == PIC_ACK && ack_count_reg == ACK_LAST) begin
      pc_reg <= vector_reg;
    end else if (state_reg == PIC_RUN && return_from_interrupt) begin
      pc_reg <= stack_mem[sp_reg + SP_W'(2)];
    end else if (state_reg == PIC_RUN && instr_done && !take) begin
      pc_reg <= pc_reg + 16'h0001;
    end
  end

  // Status: level follows the accepted priority so equal and worse
  // requests wait; a return restores the pushed copy.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      level_reg <= pic_pkg::PS_LEVEL_RESET;
      ien_reg   <= pic_pkg::PS_IEN_RESET;
    end else if (state_reg == PIC_ACK && ack_count_reg == ACK_LAST) begin
      level_reg <= taken_prio_reg;
    end else if (state_reg == PIC_RUN && return_from_interrupt) begin
      level_reg <= stack_mem[sp_reg + SP_W'(1)][1:0];
      ien_reg   <= stack_mem[sp_reg + SP_W'(1)][2];
    end else if (state_reg == PIC_RUN && ps_write) begin
      level_reg <= ps_level_in;
      ien_reg   <= ps_ien_in;
    end
  end

  // Priority bytes go out whole, one write per request, one cycle later.
  always_ff @(posedge link.clk) begin
    if (link.reset) begin
      cfg_write_reg <= 1'b0;
      cfg_addr_reg  <= 8'h00;
      cfg_data_reg  <= 8'h00;
    end else begin
      cfg_write_reg <= cfg_valid;
      cfg_addr_reg  <= cfg_addr_in;
      cfg_data_reg  <= cfg_data_in;
    end
  end

  assign link.cfg_write    = cfg_write_reg;
  assign link.cfg_addr     = cfg_addr_reg;
  assign link.cfg_data     = cfg_data_reg;
  assign link.sleep_active = (state_reg == PIC_SLEEP);
  assign program_counter   = pc_reg;
  assign stack_pointer     = sp_reg;
  assign cpu_level         = level_reg;
  assign ien               = ien_reg;
  assign accepted          = take;
  assign acknowledging     = (state_reg == PIC_ACK);
  assign sleeping          = (state_reg == PIC_SLEEP);

endmodule

/* verification/pic_link_monitor.sv */
`timescale 1ns/100ps
// Watches the link between controller and core end; a shadow of the priority
// bytes lets each forwarded code be traced back to what software wrote.
module pic_link_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        irq_valid,
  input wire logic [1:0]  irq_priority,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0]  irq_source,
  input wire logic        wake,
  input wire logic        sleep_active,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_addr,
  input wire logic [7:0]  cfg_data
);
  logic [23:0] shadow_reg;
  logic [23:0] lagged_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Mirror of whole-byte writes; other addresses are ignored like the controller does.
  always_ff @(posedge clk) begin
    if (reset) begin
      shadow_reg <= 24'hffffff;
    end else if (cfg_write && cfg_addr >= 8'h7c && cfg_addr <= 8'h7e) begin
      shadow_reg[(cfg_addr - 8'h7c) * 8 +: 8] <= cfg_data;
    end
  end

  // The outputs are registered, so they see the fields one edge late.
  always_ff @(posedge clk) begin
    lagged_reg <= shadow_reg;
  end

  // A sleeping core that has seen a forwarded request.
  sequence s_asleep_request;
    sleep_active ##1 (sleep_active && irq_valid);
  endsequence

  AST_RESET_IDLE: assert property (disable iff (1'b0) reset |=> !irq_valid && irq_priority == 2'b11 && !wake)
    else $error("link not idle after reset");
  AST_IDLE_CODE: assert property (!irq_valid |-> irq_priority == 2'b11)
    else $error("idle priority code wrong");
  AST_NEVER_FWD: assert property (irq_valid |-> irq_priority != 2'b11)
    else $error("disabled code forwarded");
  AST_PRIO_MATCH: assert property (irq_valid |-> irq_priority == lagged_reg[{irq_source, 1'b0} +: 2])
    else $error("forwarded code differs from field");
  AST_VEC_MATCH: assert property (irq_valid |-> irq_vector == 16'hfffa - {11'h000, irq_source, 1'b0})
    else $error("vector does not match source");
  AST_SRC_RANGE: assert property (irq_valid |-> irq_source < 4'hc)
    else $error("source index out of range");
  AST_WAKE_FOLLOWS: assert property (s_asleep_request |-> ##[0:1] wake)
    else $error("sleeping core not woken");
  AST_WAKE_CAUSE: assert property (wake |-> $past(sleep_active))
    else $error("wake without sleep");
endmodule

/* verification/priority_interrupt_controller_tb.sv */
`timescale 1ns/100ps
module priority_interrupt_controller_tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] req = 12'h000;
  logic        instr_done = 1'b0;
  logic        return_from_interrupt = 1'b0;
  logic        sleep_req = 1'b0;
  logic        ps_write = 1'b0;
  logic        ps_ien_in = 1'b0;
  logic [1:0]  ps_level_in = 2'b11;
  logic        cfg_valid = 1'b0;
  logic [7:0]  cfg_addr_in = 8'h00;
  logic [7:0]  cfg_data_in = 8'h00;
  logic [15:0] program_counter;
  logic [3:0]  stack_pointer;
  logic [1:0]  cpu_level;
  logic        ien;
  logic        accepted;
  logic        acknowledging;
  logic        sleeping;
  logic [23:0] pr;
  logic [11:0] rq;
  logic [22:0] e;
  logic [3:0]  sp0;
  int          seed = 97;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n;

  pic_if pic_if_i (.clk(clk), .reset(reset));
  pic_controller pic_controller_i (.link(pic_if_i.dev_mp), .req(req));
  pic_core_end pic_core_end_i (.link(pic_if_i.cpu_mp), .instr_done(instr_done), .return_from_interrupt(return_from_interrupt),
    .sleep_req(sleep_req), .ps_write(ps_write), .ps_ien_in(ps_ien_in), .ps_level_in(ps_level_in),
    .cfg_valid(cfg_valid), .cfg_addr_in(cfg_addr_in), .cfg_data_in(cfg_data_in),
    .program_counter(program_counter), .stack_pointer(stack_pointer), .cpu_level(cpu_level),
    .ien(ien), .accepted(accepted), .acknowledging(acknowledging), .sleeping(sleeping));
  pic_link_monitor pic_link_monitor_i (.clk(clk), .reset(reset), .irq_valid(pic_if_i.irq_valid),
    .irq_priority(pic_if_i.irq_priority), .irq_vector(pic_if_i.irq_vector),
    .irq_source(pic_if_i.irq_source), .wake(pic_if_i.wake), .sleep_active(pic_if_i.sleep_active),
    .cfg_write(pic_if_i.cfg_write), .cfg_addr(pic_if_i.cfg_addr), .cfg_data(pic_if_i.cfg_data));

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Expected {valid, code, vector, source}: best rank wins, ties go to the lowest input.
  function automatic logic [22:0] exp_irq(input logic [23:0] p, input logic [11:0] r);
    logic [1:0] best;
    logic [1:0] code;
    logic [1:0] rank;
    logic [3:0] src;
    best = 2'd3;
    code = 2'b11;
    src = 4'h0;
    for (int i = 0; i < 12; i++) begin
      rank = p[2*i+1] ? (p[2*i] ? 2'd3 : 2'd2) : 2'd1;
      if (r[i] && rank < best) begin
        best = rank;
        code = p[2*i +: 2];
        src = 4'(i);
      end
    end
    return {best != 2'd3, code, 16'hfffa - {11'h000, src, 1'b0}, src};
  endfunction

  // Three whole bytes, then a stray write to an unmapped address that must change nothing.
  task automatic set_prio(input logic [23:0] p);
    for (int b = 0; b < 4; b++) begin
      @(negedge clk);
      cfg_valid = 1'b1;
      cfg_addr_in = 8'h7c + 8'(b);
      cfg_data_in = (b < 3) ? p[8*b +: 8] : 8'h00;
    end
    @(negedge clk);
    cfg_valid = 1'b0;
  endtask

  task automatic ps_set(input logic en, input logic [1:0] lvl);
    @(negedge clk);
    ps_write = 1'b1;
    ps_ien_in = en;
    ps_level_in = lvl;
    @(negedge clk);
    ps_write = 1'b0;
  endtask

  // One instruction end; the accept decision is combinational in that cycle.
  task automatic step_done(input logic exp_acc);
    @(negedge clk);
    instr_done = 1'b1;
    #1;
    check(accepted === exp_acc, "accept decision");
    @(negedge clk);
    instr_done = 1'b0;
  endtask

  // Hang guard.
  initial begin
    #400000;
    check(1'b0, "run timed out");
    tally_and_finish();
  end

  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    req = 12'hfff;
    repeat (3) @(negedge clk);
    check(pic_if_i.irq_valid === 1'b0, "request forwarded before config");
    // Random arbitration, with corners: all tied at the top code, only the last input enabled.
    for (int k = 0; k < 30; k++) begin
      pr = (k == 0) ? 24'h000000 : (k == 1) ? 24'h3fffff : 24'($random(seed));
      rq = (k < 2) ? 12'hfff : 12'($random(seed));
      set_prio(pr);
      req = rq;
      repeat (3) @(negedge clk);
      e = exp_irq(pr, rq);
      check(pic_if_i.irq_valid === e[22] && pic_if_i.irq_priority === e[21:20], "valid or code");
      if (e[22]) begin
        check(pic_if_i.irq_vector === e[19:4] && pic_if_i.irq_source === e[3:0], "vector or source");
      end
    end
    // Input 1 at the higher code against a core at the lower level.
    set_prio(24'hfffff7);
    req = 12'h002;
    ps_set(1'b1, 2'b10);
    repeat (2) @(negedge clk);
    sp0 = stack_pointer;
    step_done(1'b1);
    n = 0;
    while (acknowledging === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(n == pic_pkg::ACK_CLKS, "acknowledge length");
    check(program_counter === 16'hfff8 && cpu_level === 2'b01, "vector or level load");
    check(stack_pointer === sp0 - 4'h2, "stack push");
    step_done(1'b0);
    req = 12'h000;
    @(negedge clk);
    return_from_interrupt = 1'b1;
    @(negedge clk);
    return_from_interrupt = 1'b0;
    @(negedge clk);
    check(stack_pointer === sp0 && cpu_level === 2'b10 && ien === 1'b1, "return restore");
    ps_set(1'b0, 2'b10);
    req = 12'h002;
    repeat (2) @(negedge clk);
    step_done(1'b0);
    // Nesting: a priority-2 handler is cut into by a priority-1 request.
    set_prio(24'hfffff6);
    ps_set(1'b1, 2'b11);
    req = 12'h001;
    repeat (2) @(negedge clk);
    step_done(1'b1);
    n = 0;
    while (acknowledging === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(n == pic_pkg::ACK_CLKS && cpu_level === 2'b10, "first level load");
    req = 12'h003;
    repeat (2) @(negedge clk);
    check(accepted === 1'b0, "accept without instruction end");
    step_done(1'b1);
    n = 0;
    while (acknowledging === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(n == pic_pkg::ACK_CLKS && program_counter === 16'hfff8 && cpu_level === 2'b01, "nested load");
    // Sleep, then wake on a request that the core will not accept.
    req = 12'h000;
    repeat (3) @(negedge clk);
    sleep_req = 1'b1;
    @(negedge clk);
    sleep_req = 1'b0;
    check(sleeping === 1'b1, "sleep entry");
    req = 12'h002;
    n = 0;
    while (sleeping === 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    check(sleeping === 1'b0 && acknowledging === 1'b0, "wake without accept");
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check(pic_if_i.irq_valid === 1'b0 && cpu_level === 2'b11 && stack_pointer === 4'hf, "second reset");
    tally_and_finish();
  end
endmodule
